// ### shared/pcu_regs.svh
// pad configuration unit: register addresses, field positions, reset values
// assumes byte addressing on a 32-bit bus; every register is one aligned word
//
// Summary of operation
// - three registers at 0x4004402C, 0x40044034, 0x40044038; hysteresis resets 1
// - bits 4:3 pick pull: 1 down, 2 up, 3 repeater; reset is pull-up
// - pull select 0 enables neither resistor, pin floats
// - invert bit clear: pad level passes to internal logic unchanged
// - invert bit set: pad level is complemented before internal logic
// - bit 10 set: pad only drives low and releases for high
`ifndef PCU_REGS_SVH
`define PCU_REGS_SVH

// ----------------------------------------------------------------
// addresses
// ----------------------------------------------------------------
`define PCU_ADDR_PIN1 32'h4004402C
`define PCU_ADDR_PIN9 32'h40044034
`define PCU_ADDR_PIN8 32'h40044038

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PCU_PULL_LSB 3
`define PCU_PULL_MSB 4
`define PCU_HYST_BIT 5
`define PCU_INVERT_BIT 6
`define PCU_RSV_LSB 7
`define PCU_RSV_MSB 9
`define PCU_DRAIN_BIT 10

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PCU_PULL_RST 2'h2
`define PCU_HYST_RST 1'h1
`define PCU_INVERT_RST 1'h0
`define PCU_DRAIN_RST 1'h0
`define PCU_RSV_VAL 3'h1

`endif

// ### shared/pcu_pkg.sv
// pad configuration unit: shared types
// assumes the field layout in pcu_regs.svh
package pcu_pkg;

   typedef enum logic [1:0] {
      PCU_PULL_NONE = 2'b00,
      PCU_PULL_DOWN = 2'b01,
      PCU_PULL_UP = 2'b10,
      PCU_PULL_REPEAT = 2'b11
   } pcu_pull_t;

   typedef struct packed {
      logic pseudo_open_drain_enable;
      logic input_invert;
      logic hysteresis_enable;
      pcu_pull_t pull_sel;
   } pcu_pin_cfg_t;

endpackage

// ### logic/pcu_wb_port.sv
// pad configuration unit: classic wishbone handshake and address decode
// assumes a single-cycle classic master that holds its request until ack
`timescale 1ns/1ns
`default_nettype none
`include "pcu_regs.svh"

module pcu_wb_port #(
   parameter int NUM_PINS = 3
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   output logic wb_ack_o,
   output logic wr_commit,
   output logic [NUM_PINS-1:0] hit
);

   typedef struct packed {
      logic ack;
   } pcu_wb_state_t;

   pcu_wb_state_t st;
   pcu_wb_state_t next_st;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   always_comb begin
      hit = '0;
      hit[0] = (wb_adr_i == `PCU_ADDR_PIN1);
      hit[1] = (wb_adr_i == `PCU_ADDR_PIN9);
      hit[2] = (wb_adr_i == `PCU_ADDR_PIN8);
   end

   // ack one cycle after the request, dropped the cycle after; unmapped
   // addresses are acked too so a stray access never hangs the bus
   always_comb begin
      next_st = st;
      next_st.ack = wb_cyc_i & wb_stb_i & ~st.ack;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign wb_ack_o = st.ack;
   // write lands at the very edge where the master samples ack
   assign wr_commit = st.ack & wb_cyc_i & wb_stb_i & wb_we_i;

endmodule
`default_nettype wire

// ### logic/pcu_pad_cell.sv
// pad configuration unit: control for one pad cell
// assumes pad_in comes straight from the pin, core signals from clk_sys logic
`timescale 1ns/1ns
`default_nettype none

module pcu_pad_cell (
   input wire logic clk_sys,
   input wire logic rst,
   input wire pcu_pkg::pcu_pin_cfg_t cfg,
   input wire logic pad_in,
   input wire logic core_out,
   input wire logic core_oe,
   output logic core_in,
   output logic pad_out,
   output logic pad_oe,
   output logic pull_up_en,
   output logic pull_down_en,
   output logic repeater_en,
   output logic hysteresis_enable
);

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic core_in;
      logic pad_out;
      logic pad_oe;
      logic pull_up;
      logic pull_down;
      logic repeater;
      logic hysteresis;
   } pcu_pad_state_t;

   pcu_pad_state_t st;
   pcu_pad_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.sync1 = pad_in;
      next_st.sync2 = st.sync1;
      // inversion applied after the synchroniser, never on its first stage
      next_st.core_in = cfg.input_invert ? ~st.sync2 : st.sync2;
      next_st.pull_up = (cfg.pull_sel == pcu_pkg::PCU_PULL_UP);
      next_st.pull_down = (cfg.pull_sel == pcu_pkg::PCU_PULL_DOWN);
      next_st.repeater = (cfg.pull_sel == pcu_pkg::PCU_PULL_REPEAT);
      next_st.hysteresis = cfg.hysteresis_enable;
      if (cfg.pseudo_open_drain_enable) begin
         // drive low only; a high is just a release, no true open drain
         next_st.pad_out = 1'b0;
         next_st.pad_oe = core_oe & ~core_out;
      end else begin
         next_st.pad_out = core_out;
         next_st.pad_oe = core_oe;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st <= '0;
         st.pull_up <= 1'b1;
         st.hysteresis <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign core_in = st.core_in;
   assign pad_out = st.pad_out;
   assign pad_oe = st.pad_oe;
   assign pull_up_en = st.pull_up;
   assign pull_down_en = st.pull_down;
   assign repeater_en = st.repeater;
   assign hysteresis_enable = st.hysteresis;

endmodule
`default_nettype wire

// ### logic/pcu_config_regs.sv
// pad configuration unit: register bank for port 0 pins 1, 9 and 8
// assumes a classic wishbone master on clk_sys; index 0 = pin 1, 1 = pin 9, 2 = pin 8
`timescale 1ns/1ns
`default_nettype none
`include "pcu_regs.svh"

module pcu_config_regs #(
   parameter int NUM_PINS = 3
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [NUM_PINS-1:0] pad_in,
   input wire logic [NUM_PINS-1:0] core_out,
   input wire logic [NUM_PINS-1:0] core_oe,
   output logic [NUM_PINS-1:0] core_in,
   output logic [NUM_PINS-1:0] pad_out,
   output logic [NUM_PINS-1:0] pad_oe,
   output logic [NUM_PINS-1:0] pull_up_en,
   output logic [NUM_PINS-1:0] pull_down_en,
   output logic [NUM_PINS-1:0] repeater_en,
   output logic [NUM_PINS-1:0] hysteresis_enable
);

   typedef struct packed {
      pcu_pkg::pcu_pin_cfg_t [NUM_PINS-1:0] cfg;
      logic [31:0] rdata;
   } pcu_bank_state_t;

   pcu_bank_state_t st;
   pcu_bank_state_t next_st;
   logic wr_commit;
   logic [NUM_PINS-1:0] hit;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // reserved fields are constants here, so writes to them cannot stick
   function automatic logic [31:0] pcu_pack(input pcu_pkg::pcu_pin_cfg_t c);
      logic [31:0] w;
      w = 32'h00000000;
      w[`PCU_PULL_MSB:`PCU_PULL_LSB] = c.pull_sel;
      w[`PCU_HYST_BIT] = c.hysteresis_enable;
      w[`PCU_INVERT_BIT] = c.input_invert;
      w[`PCU_RSV_MSB:`PCU_RSV_LSB] = `PCU_RSV_VAL;
      w[`PCU_DRAIN_BIT] = c.pseudo_open_drain_enable;
      return w;
   endfunction

   // byte lane 0 carries pull, hysteresis and invert; lane 1 the drain bit
   function automatic pcu_pkg::pcu_pin_cfg_t pcu_merge(
      input pcu_pkg::pcu_pin_cfg_t c,
      input logic [3:0] sel,
      input logic [31:0] d
   );
      pcu_pkg::pcu_pin_cfg_t r;
      r = c;
      if (sel[0]) begin
         r.pull_sel = pcu_pkg::pcu_pull_t'(d[`PCU_PULL_MSB:`PCU_PULL_LSB]);
         r.hysteresis_enable = d[`PCU_HYST_BIT];
         r.input_invert = d[`PCU_INVERT_BIT];
      end
      if (sel[1]) begin
         r.pseudo_open_drain_enable = d[`PCU_DRAIN_BIT];
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // bus port
   // ----------------------------------------------------------------
   pcu_wb_port #(
      .NUM_PINS(NUM_PINS)
   ) u_port (
      .clk_sys(clk_sys),
      .rst(rst),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_ack_o(wb_ack_o),
      .wr_commit(wr_commit),
      .hit(hit)
   );

   // ----------------------------------------------------------------
   // register bank
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.rdata = 32'h00000000;
      for (int i = 0; i < NUM_PINS; i++) begin
         if (hit[i]) begin
            next_st.rdata = pcu_pack(st.cfg[i]);
         end
         if (wr_commit && hit[i]) begin
            next_st.cfg[i] = pcu_merge(st.cfg[i], wb_sel_i, wb_dat_i);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            st.cfg[i].pull_sel <= pcu_pkg::pcu_pull_t'(`PCU_PULL_RST);
            st.cfg[i].hysteresis_enable <= `PCU_HYST_RST;
            st.cfg[i].input_invert <= `PCU_INVERT_RST;
            st.cfg[i].pseudo_open_drain_enable <= `PCU_DRAIN_RST;
         end
         st.rdata <= 32'h00000000;
      end else begin
         st <= next_st;
      end
   end

   assign wb_dat_o = st.rdata;

   // ----------------------------------------------------------------
   // pad cells
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pad
      pcu_pad_cell u_cell (
         .clk_sys(clk_sys),
         .rst(rst),
         .cfg(st.cfg[g]),
         .pad_in(pad_in[g]),
         .core_out(core_out[g]),
         .core_oe(core_oe[g]),
         .core_in(core_in[g]),
         .pad_out(pad_out[g]),
         .pad_oe(pad_oe[g]),
         .pull_up_en(pull_up_en[g]),
         .pull_down_en(pull_down_en[g]),
         .repeater_en(repeater_en[g]),
         .hysteresis_enable(hysteresis_enable[g])
      );
   end

endmodule
`default_nettype wire

// ### dv/pcu_props.sv
// pad configuration unit: concurrent checks on bus and pad control ports
// assumes binding onto pcu_config_regs, index 0 = pin 1, 1 = pin 9, 2 = pin 8
`timescale 1ns/1ns
`default_nettype none
`include "pcu_regs.svh"

module pcu_props #(
   parameter int NUM_PINS = 3
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [NUM_PINS-1:0] pull_up_en,
   input wire logic [NUM_PINS-1:0] pull_down_en,
   input wire logic [NUM_PINS-1:0] repeater_en,
   input wire logic [NUM_PINS-1:0] hysteresis_enable
);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   wire logic mapped = wb_adr_i == `PCU_ADDR_PIN1 || wb_adr_i == `PCU_ADDR_PIN9
      || wb_adr_i == `PCU_ADDR_PIN8;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_wr_ack;
      wb_ack_o && wb_we_i && wb_sel_i[0];
   endsequence
   a_ack_next: assert property (s_req |=> wb_ack_o)
      else $error("no ack one cycle after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_rsv_read: assert property (wb_ack_o && !wb_we_i && mapped |-> wb_dat_o[9:7] == 3'h1
      && wb_dat_o[2:0] == 3'h0 && wb_dat_o[31:11] == 21'h0)
      else $error("reserved bits read wrong");
   a_unmap_zero: assert property (wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_pull_excl: assert property ((pull_up_en & pull_down_en) == '0
      && (repeater_en & (pull_up_en | pull_down_en)) == '0)
      else $error("pull controls overlap");
   a_float_wr: assert property (s_wr_ack ##0 wb_adr_i == `PCU_ADDR_PIN1
      && wb_dat_i[4:3] == 2'h0 |-> ##2 !pull_up_en[0] && !pull_down_en[0] && !repeater_en[0])
      else $error("pull none left a resistor on");
   a_hyst_follow: assert property (s_wr_ack ##0 wb_adr_i == `PCU_ADDR_PIN9
      |-> ##2 hysteresis_enable[1] == $past(wb_dat_i[5], 2))
      else $error("hysteresis not following write");
   a_reset_vals: assert property (disable iff (1'b0) rst |=> !wb_ack_o
      && pull_up_en == {NUM_PINS{1'b1}} && hysteresis_enable == {NUM_PINS{1'b1}}
      && pull_down_en == '0)
      else $error("reset state wrong");
endmodule

bind pcu_config_regs pcu_props #(.NUM_PINS(NUM_PINS)) u_props (.clk_sys, .rst, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pull_up_en,
   .pull_down_en, .repeater_en, .hysteresis_enable);
`default_nettype wire

// ### dv/pcu_config_regs_tb.sv
// pad configuration unit: self-checking bench driving bus and pad ports
// assumes the checker is bound from pcu_props.sv
`timescale 1ns/1ns
`default_nettype none
`include "pcu_regs.svh"

module pcu_config_regs_tb;
   // ----------------------------------------------------------------
   // bench
   // ----------------------------------------------------------------
   logic clk_sys = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack;
   logic [31:0] adr = 0, wdat = 0, rdat, dato;
   logic [3:0] sel = 0;
   logic [2:0] pad_in = 3'h0, core_out = 3'h0, core_oe = 3'h0;
   logic [2:0] core_in, pad_out, pad_oe, pu, pd, rep, hyst_en;
   int fails = 0, checks = 0, cycles = 0;
   always #5 clk_sys = ~clk_sys;
   pcu_config_regs #(.NUM_PINS(3)) dut (.clk_sys, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato),
      .wb_ack_o(ack), .pad_in, .core_out, .core_oe, .core_in, .pad_out, .pad_oe,
      .pull_up_en(pu), .pull_down_en(pd), .repeater_en(rep), .hysteresis_enable(hyst_en));

   task automatic close_out;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // request held until ack is sampled; read data taken at that edge
   task automatic bus(input logic w, input logic [31:0] a, input logic [3:0] s,
                      input logic [31:0] d);
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      do @(posedge clk_sys); while (ack !== 1'b1);
      rdat = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic settle;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic t_reset;
      bus(1'b0, `PCU_ADDR_PIN1, 4'hF, 32'h0);
      chk("pin1", 32'h000000B0, rdat);
      bus(1'b0, `PCU_ADDR_PIN9, 4'hF, 32'h0);
      chk("pin9", 32'h000000B0, rdat);
      bus(1'b0, `PCU_ADDR_PIN8, 4'hF, 32'h0);
      chk("pin8", 32'h000000B0, rdat);
      chk("pull_up", 3'h7, pu);
      chk("hyst", 3'h7, hyst_en);
   endtask
   task automatic t_pull;
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, `PCU_ADDR_PIN1, 4'h1, 32'(m) << 3);
         settle;
         chk("pull_up", m == 2, pu[0]);
         chk("pull_down", m == 1, pd[0]);
         chk("repeat", m == 3, rep[0]);
         bus(1'b0, `PCU_ADDR_PIN1, 4'hF, 32'h0);
         chk("pin1", (32'(m) << 3) | 32'h80, rdat);
      end
   endtask
   task automatic t_rsv;
      bus(1'b1, `PCU_ADDR_PIN9, 4'hF, 32'hFFFFFFFF);
      bus(1'b0, `PCU_ADDR_PIN9, 4'hF, 32'h0);
      chk("pin9", 32'h000004F8, rdat);
      // lane 0 only: hysteresis goes off, the drain bit in lane 1 must survive
      bus(1'b1, `PCU_ADDR_PIN9, 4'h1, 32'h00000058);
      bus(1'b0, `PCU_ADDR_PIN9, 4'hF, 32'h0);
      chk("pin9", 32'h000004D8, rdat);
      chk("hyst", 1'b0, hyst_en[1]);
      bus(1'b1, 32'h40044030, 4'hF, 32'hFFFFFFFF);
      bus(1'b0, 32'h40044030, 4'hF, 32'h0);
      chk("unmapped", 32'h0, rdat);
      bus(1'b0, `PCU_ADDR_PIN8, 4'hF, 32'h0);
      chk("pin8", 32'h000000B0, rdat);
   endtask
   task automatic t_drain;
      @(posedge clk_sys);
      core_oe <= 3'h7;
      core_out <= 3'h0;
      settle;
      chk("drain_oe", 1'b1, pad_oe[1]);
      chk("drain_out", 1'b0, pad_out[1]);
      @(posedge clk_sys);
      core_out <= 3'h7;
      settle;
      chk("drain_release", 1'b0, pad_oe[1]);
      chk("drain_out", 1'b0, pad_out[1]);
      chk("push_out", 1'b1, pad_out[0]);
      chk("push_oe", 1'b1, pad_oe[0]);
   endtask
   task automatic t_invert;
      @(posedge clk_sys);
      pad_in <= 3'h7;
      settle;
      chk("core_in", 1'b1, core_in[2]);
      chk("core_in_invert", 1'b0, core_in[1]);
      bus(1'b1, `PCU_ADDR_PIN8, 4'h1, 32'h00000040);
      settle;
      chk("core_in_invert", 1'b0, core_in[2]);
      @(posedge clk_sys);
      pad_in <= 3'h0;
      settle;
      chk("core_in_invert", 1'b1, core_in[2]);
   endtask
   // a reset in mid-run must restore every field the earlier scenarios changed
   task automatic t_mid_reset;
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset;
      chk("repeat", 3'h0, rep);
      chk("core_in", 3'h0, core_in);
   endtask
   // whole run is well under a thousand cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         close_out;
      end
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 0;
      t_reset;
      t_pull;
      t_rsv;
      t_drain;
      t_invert;
      t_mid_reset;
      close_out;
   end
endmodule
`default_nettype wire
